// ===== src/afp_bit_counter.sv
// Population counter for one operand.
// Purely combinational; the parent registers the count.
`timescale 1ns/1ns
module afp_bit_counter #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned CNT_W = 6
) (
    input  wire logic [WIDTH-1:0] bits,
    output logic      [CNT_W-1:0] count
);

    ////////////////////////////////////////////////////////////////////////
    // Width check
    if (CNT_W < $clog2(WIDTH + 1)) begin : g_bad_cnt
        $error("afp_bit_counter: CNT_W too narrow for WIDTH");
    end

    ////////////////////////////////////////////////////////////////////////
    // Count ones
    always_comb begin
        count = '0;
        for (int i = 0; i < WIDTH; i++) begin
            count = count + CNT_W'(bits[i]);
        end
    end

endmodule : afp_bit_counter

// ===== src/afp_core.sv
// Primitive operation datapath: shifts, add/sub flags, widening,
// population count, sized memory items, mode predicates, zero fields.
// Assumes operands are synchronous to mclk; results appear one edge later.
`timescale 1ns/1ns
module afp_core #(
    parameter int unsigned DATA_W = 32
) (
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    input  wire logic                        op_valid,
    input  wire logic [afp_pkg::OP_W-1:0]    op_code,
    input  wire logic [DATA_W-1:0]           opnd_a,
    input  wire logic [DATA_W-1:0]           opnd_b,
    input  wire logic [afp_pkg::SHAMT_W-1:0] shamt,
    input  wire logic [afp_pkg::WIDX_W-1:0]  widen_top,
    input  wire logic [DATA_W-1:0]           mem_addr,
    input  wire logic [afp_pkg::SIZE_W-1:0]  mem_size,
    input  wire logic [DATA_W-1:0]           mem_word,
    input  wire logic [DATA_W-1:0]           zfield_mask,
    input  wire logic [afp_pkg::MODE_W-1:0]  mode,
    output logic                             result_valid,
    output logic      [DATA_W-1:0]           result,
    output logic                             add_carry_out,
    output logic                             sub_borrow_out,
    output logic                             signed_overflow_out,
    output logic      [afp_pkg::CNT_W-1:0]   set_bit_count,
    output logic      [DATA_W-1:0]           mem_aligned_addr,
    output logic                             op_error,
    output logic                             mode_has_saved_status,
    output logic                             privileged_mode_flag
);

    ////////////////////////////////////////////////////////////////////////
    // Width check
    if (DATA_W != afp_pkg::WORD_W) begin : g_bad_width
        $error("afp_core: DATA_W must equal the word width");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [DATA_W-1:0] sign_widen(
        input logic [DATA_W-1:0]          val,
        input logic [afp_pkg::WIDX_W-1:0] top
    );
        logic [DATA_W-1:0] out;
        out = '0;
        for (int i = 0; i < DATA_W; i++) begin
            out[i] = (i <= int'(top)) ? val[i] : val[top];
        end
        return out;
    endfunction : sign_widen
    function automatic logic [DATA_W-1:0] zero_widen(
        input logic [DATA_W-1:0]          val,
        input logic [afp_pkg::WIDX_W-1:0] top
    );
        logic [DATA_W-1:0] out;
        out = '0;
        for (int i = 0; i < DATA_W; i++) begin
            out[i] = (i <= int'(top)) ? val[i] : 1'b0;
        end
        return out;
    endfunction : zero_widen
    function automatic logic size_ok(input logic [afp_pkg::SIZE_W-1:0] sz);
        return (sz == afp_pkg::SIZE_BYTE) || (sz == afp_pkg::SIZE_HALF)
            || (sz == afp_pkg::SIZE_WORD);
    endfunction : size_ok
    function automatic logic [DATA_W-1:0] align_addr(
        input logic [DATA_W-1:0]          addr,
        input logic [afp_pkg::SIZE_W-1:0] sz
    );
        logic [DATA_W-1:0] out;
        out = addr;
        if (sz == afp_pkg::SIZE_HALF) begin
            out[0] = 1'b0;
        end else if (sz == afp_pkg::SIZE_WORD) begin
            out[1:0] = 2'h0;
        end
        return out;
    endfunction : align_addr
    function automatic logic [DATA_W-1:0] load_item(
        input logic [DATA_W-1:0]          word,
        input logic [DATA_W-1:0]          addr,
        input logic [afp_pkg::SIZE_W-1:0] sz
    );
        logic [DATA_W-1:0] out;
        out = word;
        if (sz == afp_pkg::SIZE_BYTE) begin
            out = DATA_W'(word[addr[1:0]*afp_pkg::BYTE_W +: afp_pkg::BYTE_W]);
        end else if (sz == afp_pkg::SIZE_HALF) begin
            out = DATA_W'(word[addr[1]*afp_pkg::HALF_W +: afp_pkg::HALF_W]);
        end
        return out;
    endfunction : load_item

    ////////////////////////////////////////////////////////////////////////
    // Combinational operations
    logic [DATA_W:0]             sum_ext;
    logic [DATA_W:0]             diff_ext;
    logic [2*DATA_W-1:0]         ror_ext;
    logic [afp_pkg::CNT_W-1:0]   ones;
    logic [DATA_W-1:0]           next_result;
    logic                        next_carry;
    logic                        next_borrow;
    logic                        next_overflow;
    logic                        next_error;
    logic [DATA_W-1:0]           next_addr;

    afp_bit_counter #(
        .WIDTH (DATA_W),
        .CNT_W (afp_pkg::CNT_W)
    ) u_bit_counter (
        .bits  (opnd_a),
        .count (ones)
    );

    assign sum_ext  = {1'b0, opnd_a} + {1'b0, opnd_b};
    assign diff_ext = {1'b0, opnd_a} - {1'b0, opnd_b};
    assign ror_ext  = {opnd_a, opnd_a} >> shamt;

    always_comb begin
        next_result   = afp_pkg::WORD_RST;
        next_carry    = afp_pkg::FLAG_RST;
        next_borrow   = afp_pkg::FLAG_RST;
        next_overflow = afp_pkg::FLAG_RST;
        next_error    = 1'b0;
        next_addr     = mem_addr;
        case (op_code)
            afp_pkg::OP_ASR: begin
                next_result = DATA_W'($signed(opnd_a) >>> shamt);
            end
            afp_pkg::OP_LSL: begin
                next_result = opnd_a << shamt;
            end
            afp_pkg::OP_LSR: begin
                next_result = opnd_a >> shamt;
            end
            afp_pkg::OP_ROR: begin
                next_result = ror_ext[DATA_W-1:0];
            end
            afp_pkg::OP_ADD: begin
                next_result   = sum_ext[DATA_W-1:0];
                next_carry    = sum_ext[DATA_W];
                next_overflow = (opnd_a[DATA_W-1] == opnd_b[DATA_W-1])
                    && (sum_ext[DATA_W-1] != opnd_a[DATA_W-1]);
            end
            afp_pkg::OP_SUB: begin
                next_result   = diff_ext[DATA_W-1:0];
                next_borrow   = diff_ext[DATA_W];
                next_overflow = (opnd_a[DATA_W-1] != opnd_b[DATA_W-1])
                    && (diff_ext[DATA_W-1] != opnd_a[DATA_W-1]);
            end
            afp_pkg::OP_WIDEN: begin
                next_result = sign_widen(opnd_a, widen_top);
            end
            afp_pkg::OP_ZEXT: begin
                next_result = zero_widen(opnd_a, widen_top);
            end
            afp_pkg::OP_POPCNT: begin
                next_result = DATA_W'(ones);
            end
            afp_pkg::OP_LOAD: begin
                next_error  = !size_ok(mem_size);
                next_addr   = align_addr(mem_addr, mem_size);
                next_result = load_item(mem_word, mem_addr, mem_size);
            end
            afp_pkg::OP_FETCH16: begin
                next_addr   = align_addr(mem_addr, afp_pkg::SIZE_HALF);
                next_result = load_item(mem_word, mem_addr, afp_pkg::SIZE_HALF);
            end
            afp_pkg::OP_ZFIELD: begin
                next_result = opnd_a & ~zfield_mask;
            end
            default: begin
                next_error = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Result registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            result_valid <= afp_pkg::FLAG_RST;
        end else begin
            result_valid <= op_valid;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            result           <= afp_pkg::WORD_RST;
            mem_aligned_addr <= afp_pkg::WORD_RST;
            op_error         <= afp_pkg::FLAG_RST;
        end else if (op_valid) begin
            result           <= next_result;
            mem_aligned_addr <= next_addr;
            op_error         <= next_error;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            add_carry_out       <= afp_pkg::FLAG_RST;
            sub_borrow_out      <= afp_pkg::FLAG_RST;
            signed_overflow_out <= afp_pkg::FLAG_RST;
        end else if (op_valid) begin
            add_carry_out       <= next_carry;
            sub_borrow_out      <= next_borrow;
            signed_overflow_out <= next_overflow;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            set_bit_count <= afp_pkg::CNT_RST;
        end else if (op_valid) begin
            set_bit_count <= ones;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode predicates
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode_has_saved_status <= afp_pkg::FLAG_RST;
            privileged_mode_flag  <= afp_pkg::FLAG_RST;
        end else begin
            mode_has_saved_status <= (mode != afp_pkg::MODE_USER)
                && (mode != afp_pkg::MODE_SYSTEM);
            privileged_mode_flag  <= (mode != afp_pkg::MODE_USER);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_asr;
        @(posedge mclk) disable iff (!rst_n)
        op_valid && op_code == afp_pkg::OP_ASR
        |=> result == DATA_W'($signed($past(opnd_a)) >>> $past(shamt));
    endproperty
    a_asr: assert property (p_asr) else $error("asr result wrong");
    property p_lsl;
        @(posedge mclk) disable iff (!rst_n)
        op_valid && op_code == afp_pkg::OP_LSL
        |=> (result >> $past(shamt)) == (($past(opnd_a) << $past(shamt)) >> $past(shamt))
            && ((result << (DATA_W - 32'($past(shamt)))) == '0 || $past(shamt) == '0);
    endproperty
    a_lsl: assert property (p_lsl) else $error("lsl low bits not zero");
    property p_lsr;
        @(posedge mclk) disable iff (!rst_n)
        op_valid && op_code == afp_pkg::OP_LSR
        |=> result == ($past(opnd_a) >> $past(shamt));
    endproperty
    a_lsr: assert property (p_lsr) else $error("lsr result wrong");
    property p_ror;
        @(posedge mclk) disable iff (!rst_n)
        op_valid && op_code == afp_pkg::OP_ROR
        |=> $countones(result) == $countones($past(opnd_a))
            && result[DATA_W-1-$past(shamt)] == $past(opnd_a[DATA_W-1]);
    endproperty
    a_ror: assert property (p_ror) else $error("ror lost bits");
    property p_borrow;
        @(posedge mclk) disable iff (!rst_n)
        op_valid && op_code == afp_pkg::OP_SUB
        |=> sub_borrow_out == ($past(opnd_a) < $past(opnd_b));
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow wrong");
    property p_carry;
        @(posedge mclk) disable iff (!rst_n)
        op_valid && op_code == afp_pkg::OP_ADD
        |=> add_carry_out == (result < $past(opnd_a));
    endproperty
    a_carry: assert property (p_carry) else $error("carry wrong");
    property p_add_ovf;
        @(posedge mclk) disable iff (!rst_n)
        op_valid && op_code == afp_pkg::OP_ADD
        |=> signed_overflow_out == ($past(opnd_a[DATA_W-1]) == $past(opnd_b[DATA_W-1])
            && result[DATA_W-1] != $past(opnd_a[DATA_W-1]));
    endproperty
    a_add_ovf: assert property (p_add_ovf) else $error("add overflow wrong");
    property p_sub_ovf;
        @(posedge mclk) disable iff (!rst_n)
        op_valid && op_code == afp_pkg::OP_SUB
        |=> signed_overflow_out == ($past(opnd_a[DATA_W-1]) != $past(opnd_b[DATA_W-1])
            && result[DATA_W-1] != $past(opnd_a[DATA_W-1]));
    endproperty
    a_sub_ovf: assert property (p_sub_ovf) else $error("sub overflow wrong");
    property p_size;
        @(posedge mclk) disable iff (!rst_n)
        op_valid && op_code == afp_pkg::OP_LOAD
        |=> op_error == !($past(mem_size) inside {3'h1, 3'h2, 3'h4});
    endproperty
    a_size: assert property (p_size) else $error("size check wrong");
    property p_align;
        @(posedge mclk) disable iff (!rst_n)
        op_valid && op_code == afp_pkg::OP_LOAD && mem_size == afp_pkg::SIZE_WORD
        |=> mem_aligned_addr[1:0] == 2'h0
            && mem_aligned_addr[DATA_W-1:2] == $past(mem_addr[DATA_W-1:2]);
    endproperty
    a_align: assert property (p_align) else $error("word alignment wrong");
    property p_zext;
        @(posedge mclk) disable iff (!rst_n)
        op_valid && op_code == afp_pkg::OP_LOAD && mem_size == afp_pkg::SIZE_BYTE
        |=> result[DATA_W-1:8] == '0;
    endproperty
    a_zext: assert property (p_zext) else $error("byte load not zero-extended");
    property p_widen;
        @(posedge mclk) disable iff (!rst_n)
        op_valid && op_code == afp_pkg::OP_WIDEN
        |=> result[DATA_W-1] == $past(opnd_a[widen_top])
            && result[$past(widen_top)] == $past(opnd_a[widen_top]);
    endproperty
    a_widen: assert property (p_widen) else $error("sign widen wrong");
    property p_pop;
        @(posedge mclk) disable iff (!rst_n)
        op_valid |=> 32'(set_bit_count) == $countones($past(opnd_a));
    endproperty
    a_pop: assert property (p_pop) else $error("bit count wrong");
    property p_modes;
        @(posedge mclk) disable iff (!rst_n)
        ##1 mode_has_saved_status |-> privileged_mode_flag
            && $past(mode) != afp_pkg::MODE_SYSTEM;
    endproperty
    a_modes: assert property (p_modes) else $error("saved status predicate wrong");
    property p_priv;
        @(posedge mclk) disable iff (!rst_n)
        mode == afp_pkg::MODE_USER |=> !privileged_mode_flag && !mode_has_saved_status;
    endproperty
    a_priv: assert property (p_priv) else $error("user mode privileged");
    property p_zfield;
        @(posedge mclk) disable iff (!rst_n)
        op_valid && op_code == afp_pkg::OP_ZFIELD |=> (result & $past(zfield_mask)) == '0;
    endproperty
    a_zfield: assert property (p_zfield) else $error("zero field read nonzero");
    property p_live;
        @(posedge mclk) disable iff (!rst_n)
        op_valid |=> result_valid;
    endproperty
    a_live: assert property (p_live) else $error("no result for operation");

endmodule : afp_core

// ===== src/afp_pkg.sv
// Shared constants for the arithmetic and flag primitive datapath.
// Assumes a single 100 MHz core clock and a 32-bit word machine.
package afp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Data widths
    localparam int unsigned BYTE_W  = 8;
    localparam int unsigned HALF_W  = 16;
    localparam int unsigned WORD_W  = 32;
    localparam int unsigned CNT_W   = 6;
    localparam int unsigned SHAMT_W = 5;
    localparam int unsigned WIDX_W  = 5;
    localparam int unsigned OP_W    = 4;
    localparam int unsigned SIZE_W  = 3;
    localparam int unsigned MODE_W  = 5;

    ////////////////////////////////////////////////////////////////////////
    // Operation codes
    localparam logic [3:0] OP_ASR     = 4'h0;
    localparam logic [3:0] OP_LSL     = 4'h1;
    localparam logic [3:0] OP_LSR     = 4'h2;
    localparam logic [3:0] OP_ROR     = 4'h3;
    localparam logic [3:0] OP_ADD     = 4'h4;
    localparam logic [3:0] OP_SUB     = 4'h5;
    localparam logic [3:0] OP_WIDEN   = 4'h6;
    localparam logic [3:0] OP_ZEXT    = 4'h7;
    localparam logic [3:0] OP_POPCNT  = 4'h8;
    localparam logic [3:0] OP_LOAD    = 4'h9;
    localparam logic [3:0] OP_FETCH16 = 4'hA;
    localparam logic [3:0] OP_ZFIELD  = 4'hB;

    ////////////////////////////////////////////////////////////////////////
    // Memory item sizes in bytes
    localparam logic [2:0] SIZE_BYTE = 3'h1;
    localparam logic [2:0] SIZE_HALF = 3'h2;
    localparam logic [2:0] SIZE_WORD = 3'h4;

    ////////////////////////////////////////////////////////////////////////
    // Processor mode codes
    localparam logic [4:0] MODE_USER   = 5'h10;
    localparam logic [4:0] MODE_SYSTEM = 5'h1F;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [5:0]  CNT_RST  = 6'h00;
    localparam logic        FLAG_RST = 1'b0;

endpackage : afp_pkg

// ===== tb/tb_top.sv
// Self-checking bench for the primitive operation datapath.
// Assumes afp_pkg is compiled first; drives afp_core directly with no partner.
`timescale 1ns/1ns
module tb_top;

    ////////////////////////////////////////////////////////////////////////
    // Expected result of one accepted operation
    typedef struct packed {
        logic [31:0] res;
        logic        carry;
        logic        borrow;
        logic        ovf;
        logic [5:0]  cnt;
        logic [31:0] addr;
        logic        err;
    } afp_note_t;

    `define CHK(got, exp) \
        begin \
            total_checks++; \
            if ((got) !== (exp)) begin \
                failures++; \
                $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
            end \
        end

    logic        mclk = 1'h0;
    logic        rst_n;
    logic        op_valid;
    logic [3:0]  op_code;
    logic [31:0] opnd_a;
    logic [31:0] opnd_b;
    logic [4:0]  shamt;
    logic [4:0]  widen_top;
    logic [31:0] mem_addr;
    logic [2:0]  mem_size;
    logic [31:0] mem_word;
    logic [31:0] zfield_mask;
    logic [4:0]  mode;
    logic        result_valid;
    logic [31:0] result;
    logic        add_carry_out;
    logic        sub_borrow_out;
    logic        signed_overflow_out;
    logic [5:0]  set_bit_count;
    logic [31:0] mem_aligned_addr;
    logic        op_error;
    logic        mode_has_saved_status;
    logic        privileged_mode_flag;
    logic        taken  = 1'h0;
    logic        rst_q  = 1'h0;
    logic [4:0]  mode_q = 5'h00;
    logic        saved_exp = 1'h0;
    int          failures = 0;
    int          total_checks = 0;
    int          seed = 32'hede7;
    afp_note_t   notes[$];
    afp_note_t   got_n;
    logic [2:0]  size_tab[6] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h7};

    always #5 mclk = ~mclk;

    afp_core uut (
        .mclk                  (mclk),
        .rst_n                 (rst_n),
        .op_valid              (op_valid),
        .op_code               (op_code),
        .opnd_a                (opnd_a),
        .opnd_b                (opnd_b),
        .shamt                 (shamt),
        .widen_top             (widen_top),
        .mem_addr              (mem_addr),
        .mem_size              (mem_size),
        .mem_word              (mem_word),
        .zfield_mask           (zfield_mask),
        .mode                  (mode),
        .result_valid          (result_valid),
        .result                (result),
        .add_carry_out         (add_carry_out),
        .sub_borrow_out        (sub_borrow_out),
        .signed_overflow_out   (signed_overflow_out),
        .set_bit_count         (set_bit_count),
        .mem_aligned_addr      (mem_aligned_addr),
        .op_error              (op_error),
        .mode_has_saved_status (mode_has_saved_status),
        .privileged_mode_flag  (privileged_mode_flag)
    );

    ////////////////////////////////////////////////////////////////////////
    // Reference model of one operation from the current inputs
    function automatic afp_note_t predict();
        afp_note_t   n;
        logic [63:0] w;
        logic [32:0] s;
        logic [2:0]  sz;
        n = '0;
        n.addr = mem_addr;
        for (int i = 0; i < 32; i++) n.cnt = n.cnt + 6'(opnd_a[i]);
        sz = (op_code == afp_pkg::OP_FETCH16) ? afp_pkg::SIZE_HALF : mem_size;
        case (op_code)
            afp_pkg::OP_ASR: n.res = 32'($signed(opnd_a) >>> shamt);
            afp_pkg::OP_LSL: n.res = opnd_a << shamt;
            afp_pkg::OP_LSR: n.res = opnd_a >> shamt;
            afp_pkg::OP_ROR: begin
                w = {opnd_a, opnd_a} >> shamt;
                n.res = w[31:0];
            end
            afp_pkg::OP_ADD: begin
                s = {1'h0, opnd_a} + {1'h0, opnd_b};
                n.res = s[31:0];
                n.carry = s[32];
                n.ovf = (opnd_a[31] == opnd_b[31]) && (s[31] != opnd_a[31]);
            end
            afp_pkg::OP_SUB: begin
                n.res = opnd_a - opnd_b;
                n.borrow = opnd_a < opnd_b;
                n.ovf = (opnd_a[31] != opnd_b[31]) && (n.res[31] != opnd_a[31]);
            end
            afp_pkg::OP_WIDEN, afp_pkg::OP_ZEXT: begin
                for (int i = 0; i < 32; i++) n.res[i] = (i > int'(widen_top)) ?
                    ((op_code == afp_pkg::OP_WIDEN) & opnd_a[widen_top]) : opnd_a[i];
            end
            afp_pkg::OP_POPCNT: n.res = 32'(n.cnt);
            afp_pkg::OP_LOAD, afp_pkg::OP_FETCH16: begin
                n.res = mem_word;
                case (sz)
                    afp_pkg::SIZE_BYTE: begin
                        w = 64'(mem_word) >> {mem_addr[1:0], 3'h0};
                        n.res = {24'h00_0000, w[7:0]};
                    end
                    afp_pkg::SIZE_HALF: begin
                        w = 64'(mem_word) >> {mem_addr[1], 4'h0};
                        n.res = {16'h0000, w[15:0]};
                        n.addr = {mem_addr[31:1], 1'h0};
                    end
                    afp_pkg::SIZE_WORD: n.addr = {mem_addr[31:2], 2'h0};
                    default: n.err = 1'h1;
                endcase
            end
            afp_pkg::OP_ZFIELD: n.res = opnd_a & ~zfield_mask;
            default: n.err = 1'h1;
        endcase
        return n;
    endfunction : predict

    ////////////////////////////////////////////////////////////////////////
    // Driver
    task automatic issue();
        if (op_valid) notes.push_back(predict());
        @(posedge mclk);
        #1;
    endtask : issue

    task automatic run_batch(input int count);
        for (int i = 0; i < count; i++) begin
            op_valid = ($random(seed) & 3) != 0;
            op_code = 4'(i);
            opnd_a = $random(seed);
            opnd_b = (i % 7 == 0) ? ~opnd_a + 32'h0000_0001 : 32'($random(seed));
            shamt = (i % 5 == 0) ? 5'h00 : (i % 5 == 1) ? 5'h1F : 5'($random(seed));
            widen_top = (i % 3 == 0) ? 5'h1F : 5'($random(seed));
            mem_addr = $random(seed);
            mem_size = size_tab[$unsigned($random(seed)) % 6];
            mem_word = $random(seed);
            zfield_mask = $random(seed);
            mode = (i % 3 == 0) ? afp_pkg::MODE_USER :
                   (i % 3 == 1) ? afp_pkg::MODE_SYSTEM : 5'($random(seed));
            issue();
        end
        op_valid = 1'h0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : run_batch

    task automatic apply_reset();
        op_valid = 1'h0;
        rst_n = 1'h0;
        repeat (8) @(posedge mclk);
        #1;
        rst_n = 1'h1;
    endtask : apply_reset

    ////////////////////////////////////////////////////////////////////////
    // Monitor
    always @(posedge mclk) begin
        taken <= rst_n & op_valid;
        rst_q <= rst_n;
        mode_q <= mode;
        saved_exp <= rst_n && (mode != afp_pkg::MODE_USER) && (mode != afp_pkg::MODE_SYSTEM);
    end

    always @(negedge mclk) begin
        `CHK(result_valid, taken)
        `CHK(privileged_mode_flag, rst_q && (mode_q != afp_pkg::MODE_USER))
        `CHK(mode_has_saved_status, saved_exp)
        if (result_valid === 1'h1) begin
            `CHK(notes.size() != 0, 1'h1)
            got_n = '1;
            if (notes.size() != 0) got_n = notes.pop_front();
            `CHK(result, got_n.res)
            `CHK(add_carry_out, got_n.carry)
            `CHK(sub_borrow_out, got_n.borrow)
            `CHK(signed_overflow_out, got_n.ovf)
            `CHK(set_bit_count, got_n.cnt)
            `CHK(mem_aligned_addr, got_n.addr)
            `CHK(op_error, got_n.err)
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Verdict
    task automatic wrap_up();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    initial begin
        #200000;
        failures++;
        wrap_up();
    end

    initial begin
        rst_n = 1'h0;
        op_valid = 1'h0;
        op_code = 4'h0;
        opnd_a = 32'h0000_0000;
        opnd_b = 32'h0000_0000;
        shamt = 5'h00;
        widen_top = 5'h00;
        mem_addr = 32'h0000_0000;
        mem_size = 3'h4;
        mem_word = 32'h0000_0000;
        zfield_mask = 32'h0000_0000;
        mode = 5'h10;
        apply_reset();
        // Carry and overflow corners back to back
        op_valid = 1'h1;
        op_code = afp_pkg::OP_ADD;
        opnd_a = 32'hFFFF_FFFF;
        opnd_b = 32'h0000_0001;
        issue();
        opnd_a = 32'h7FFF_FFFF;
        issue();
        op_code = afp_pkg::OP_SUB;
        opnd_a = 32'h8000_0000;
        issue();
        opnd_a = 32'h0000_0000;
        issue();
        run_batch(320);
        apply_reset();
        run_batch(320);
        `CHK(notes.size(), 0)
        wrap_up();
    end

endmodule : tb_top
